// ===== core/regulator_mode_control_regs.sv
// Mode, set point, standby override and discharge registers of a rail controller.
// Assumes an AXI4-Lite master on clk_in and a standby request pin from outside.
//
// Overview of operation
// - In standby, nonzero low-power select sets 0.70, 0.75 or 0.80 V.
// - Normal select decodes to 0.95, 0.90, 0.85 or 0.80 V.
// - Standby exit edge loads mode bits from exit field; 00 leaves them.
// - Mode 00 disables, 01 and 10 automatic, 11 forced pulse-width.
// - Override bit at 0 forces automatic mode on its rail during standby.
// - Override acts only when the rail's mode is forced pulse-width.
// - Discharge select: none, 125, 225 or 550 ohms.
// - Override register resets with all six bits at 1.
// - Rail control resets to low-power off, exit field 10, mode 10.
// - Percentage low-power select: off, minus 4, minus 3, minus 2 percent.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module regulator_mode_control_regs (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic standby_request_n_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [7:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic standby_active_out,
    output logic [9:0] rail_b_setpoint_mv_out,
    output logic rail_b_enable_out,
    output logic rail_b_forced_pwm_out,
    output logic [5:0] rail_force_auto_out,
    output logic [9:0] io_discharge_ohms_out,
    output logic [2:0] one_volt_lp_drop_pct_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        regulator_mode_control_pkg::core_ctrl_t core;
        logic [5:0] ovr;
        logic [1:0] dis;
        logic [1:0] onev;
        logic sync1;
        logic sync2;
        logic stb_prev;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic stby;
        logic [9:0] setpt;
        logic en;
        logic fpwm;
        logic [5:0] force_auto;
        logic [9:0] ohms;
        logic [2:0] pct;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    // Register hit for a byte address; low address bits ignored
    function automatic logic [3:0] reg_hit(input logic [7:0] addr);
        reg_hit = {addr[7:2] == regulator_mode_control_pkg::IDX_CORE_B,
                   addr[7:2] == regulator_mode_control_pkg::IDX_OVR,
                   addr[7:2] == regulator_mode_control_pkg::IDX_DIS,
                   addr[7:2] == regulator_mode_control_pkg::IDX_ONEV};
    endfunction

    function automatic logic [9:0] normal_mv(input logic [1:0] sel);
        case (sel)
            regulator_mode_control_pkg::SEL_OFF: normal_mv = regulator_mode_control_pkg::MV_0P95;
            regulator_mode_control_pkg::SEL_1: normal_mv = regulator_mode_control_pkg::MV_0P90;
            regulator_mode_control_pkg::SEL_2: normal_mv = regulator_mode_control_pkg::MV_0P85;
            default: normal_mv = regulator_mode_control_pkg::MV_0P80;
        endcase
    endfunction

    function automatic logic [9:0] low_power_mv(input logic [1:0] sel);
        case (sel)
            regulator_mode_control_pkg::SEL_1: low_power_mv = regulator_mode_control_pkg::MV_0P70;
            regulator_mode_control_pkg::SEL_2: low_power_mv = regulator_mode_control_pkg::MV_0P75;
            default: low_power_mv = regulator_mode_control_pkg::MV_0P80;
        endcase
    endfunction

    logic rise_edge;
    logic [1:0] eff_mode;
    logic [3:0] wr_hit;
    logic [3:0] rd_hit;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Two-flop synchroniser; only the second stage feeds logic
        nxt_st.sync1 = standby_request_n_in;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.stb_prev = st_ff.sync2;
        rise_edge = st_ff.sync2 && !st_ff.stb_prev;
        wr_hit = reg_hit(st_ff.aw_addr);
        rd_hit = reg_hit(s_axi_araddr_in);

        // Address and data are caught separately, in either order
        if (s_axi_awvalid_in && !st_ff.aw_hold) begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !st_ff.w_hold) begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_data = s_axi_wdata_in[7:0];
            nxt_st.w_en = s_axi_wstrb_in[0];
        end

        // Commit once both halves are held and no response is pending
        if (st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid) begin
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = (wr_hit != 4'h0) ? regulator_mode_control_pkg::RESP_OKAY
                                            : regulator_mode_control_pkg::RESP_DECERR;
            if (st_ff.w_en) begin
                if (wr_hit[3]) begin
                    nxt_st.core = st_ff.w_data;
                end
                // Only the implemented low bits are stored
                if (wr_hit[2]) begin
                    nxt_st.ovr = st_ff.w_data[5:0];
                end
                if (wr_hit[1]) begin
                    nxt_st.dis = st_ff.w_data[1:0];
                end
                if (wr_hit[0]) begin
                    nxt_st.onev = st_ff.w_data[1:0];
                end
            end
        end else if (st_ff.bvalid && s_axi_bready_in) begin
            nxt_st.bvalid = 1'b0;
        end

        // Exit load wins over a bus write of the mode bits in the same cycle
        if (rise_edge && st_ff.core.exit_standby_mode_load != regulator_mode_control_pkg::SEL_OFF) begin
            nxt_st.core.rail_b_mode_field = st_ff.core.exit_standby_mode_load;
        end

        // Read path; reserved bits come back as zero
        if (s_axi_arvalid_in && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = (rd_hit != 4'h0) ? regulator_mode_control_pkg::RESP_OKAY
                                            : regulator_mode_control_pkg::RESP_DECERR;
            nxt_st.rdata = ({8{rd_hit[3]}} & st_ff.core)
                         | ({8{rd_hit[2]}} & {2'h0, st_ff.ovr})
                         | ({8{rd_hit[1]}} & {6'h00, st_ff.dis})
                         | ({8{rd_hit[0]}} & {6'h00, st_ff.onev});
        end else if (st_ff.rvalid && s_axi_rready_in) begin
            nxt_st.rvalid = 1'b0;
        end

        // Rail set point: low-power value only while in standby
        nxt_st.stby = !st_ff.sync2;
        if (!st_ff.sync2 && st_ff.core.low_power_setpoint_sel != regulator_mode_control_pkg::SEL_OFF) begin
            nxt_st.setpt = low_power_mv(st_ff.core.low_power_setpoint_sel);
        end else begin
            nxt_st.setpt = normal_mv(st_ff.core.normal_setpoint_sel);
        end

        // Override only demotes forced pulse-width, never another mode
        eff_mode = st_ff.core.rail_b_mode_field;
        if (!st_ff.sync2 && !st_ff.ovr[regulator_mode_control_pkg::OVR_RAIL_B_BIT]
            && eff_mode == regulator_mode_control_pkg::MODE_FPWM) begin
            eff_mode = regulator_mode_control_pkg::MODE_AUTO;
        end
        nxt_st.en = eff_mode != regulator_mode_control_pkg::MODE_OFF;
        nxt_st.fpwm = eff_mode == regulator_mode_control_pkg::MODE_FPWM;

        // Other rails apply this only when their own mode is forced
        nxt_st.force_auto = {6{!st_ff.sync2}} & ~st_ff.ovr;

        case (st_ff.dis)
            regulator_mode_control_pkg::SEL_OFF: nxt_st.ohms = regulator_mode_control_pkg::OHM_NONE;
            regulator_mode_control_pkg::SEL_1: nxt_st.ohms = regulator_mode_control_pkg::OHM_125;
            regulator_mode_control_pkg::SEL_2: nxt_st.ohms = regulator_mode_control_pkg::OHM_225;
            default: nxt_st.ohms = regulator_mode_control_pkg::OHM_550;
        endcase

        case (st_ff.onev)
            regulator_mode_control_pkg::SEL_OFF: nxt_st.pct = regulator_mode_control_pkg::PCT_NONE;
            regulator_mode_control_pkg::SEL_1: nxt_st.pct = regulator_mode_control_pkg::PCT_4;
            regulator_mode_control_pkg::SEL_2: nxt_st.pct = regulator_mode_control_pkg::PCT_3;
            default: nxt_st.pct = regulator_mode_control_pkg::PCT_2;
        endcase

        // Synchronous reset; synchroniser starts at the idle (high) level
        if (sys_rst_in) begin
            nxt_st = '0;
            nxt_st.core = regulator_mode_control_pkg::RST_CORE_B;
            nxt_st.ovr = regulator_mode_control_pkg::RST_OVR;
            nxt_st.dis = regulator_mode_control_pkg::RST_DIS;
            nxt_st.onev = regulator_mode_control_pkg::RST_ONEV;
            nxt_st.sync1 = 1'b1;
            nxt_st.sync2 = 1'b1;
            nxt_st.stb_prev = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        st_ff <= nxt_st;
    end

    // Ready outputs are combinational, valid, response and data from flops
    assign s_axi_awready_out = !st_ff.aw_hold;
    assign s_axi_wready_out = !st_ff.w_hold;
    assign s_axi_bvalid_out = st_ff.bvalid;
    assign s_axi_bresp_out = st_ff.bresp;
    assign s_axi_arready_out = !st_ff.rvalid;
    assign s_axi_rvalid_out = st_ff.rvalid;
    assign s_axi_rdata_out = {24'h000000, st_ff.rdata};
    assign s_axi_rresp_out = st_ff.rresp;
    assign standby_active_out = st_ff.stby;
    assign rail_b_setpoint_mv_out = st_ff.setpt;
    assign rail_b_enable_out = st_ff.en;
    assign rail_b_forced_pwm_out = st_ff.fpwm;
    assign rail_force_auto_out = st_ff.force_auto;
    assign io_discharge_ohms_out = st_ff.ohms;
    assign one_volt_lp_drop_pct_out = st_ff.pct;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_lp_setpoint;
        (!st_ff.sync2 && st_ff.core.low_power_setpoint_sel == regulator_mode_control_pkg::SEL_1)
        |=> rail_b_setpoint_mv_out == regulator_mode_control_pkg::MV_0P70;
    endproperty
    a_lp_setpoint: assert property (p_lp_setpoint) else $error("low-power set point wrong");

    property p_norm_setpoint;
        (st_ff.sync2 && st_ff.core.normal_setpoint_sel == regulator_mode_control_pkg::SEL_OFF)
        |=> rail_b_setpoint_mv_out == regulator_mode_control_pkg::MV_0P95;
    endproperty
    a_norm_setpoint: assert property (p_norm_setpoint) else $error("normal set point wrong");

    sequence s_exit_edge;
        !st_ff.sync2 ##1 st_ff.sync2 && !st_ff.stb_prev
        && st_ff.core.exit_standby_mode_load != regulator_mode_control_pkg::SEL_OFF;
    endsequence
    property p_exit_load;
        s_exit_edge |=> st_ff.core.rail_b_mode_field == $past(st_ff.core.exit_standby_mode_load);
    endproperty
    a_exit_load: assert property (p_exit_load) else $error("exit load missed");

    property p_mode_off;
        st_ff.core.rail_b_mode_field == regulator_mode_control_pkg::MODE_OFF
        |=> !rail_b_enable_out && !rail_b_forced_pwm_out;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("disabled rail enabled");

    property p_force_auto;
        (!st_ff.sync2 && !st_ff.ovr[regulator_mode_control_pkg::OVR_RAIL_B_BIT])
        |=> rail_force_auto_out[regulator_mode_control_pkg::OVR_RAIL_B_BIT] && !rail_b_forced_pwm_out;
    endproperty
    a_force_auto: assert property (p_force_auto) else $error("override not applied");

    property p_override_scope;
        (st_ff.core.rail_b_mode_field != regulator_mode_control_pkg::MODE_OFF)
        |=> rail_b_enable_out;
    endproperty
    a_override_scope: assert property (p_override_scope) else $error("override changed mode");

    property p_discharge;
        st_ff.dis == regulator_mode_control_pkg::SEL_3
        |=> io_discharge_ohms_out == regulator_mode_control_pkg::OHM_550;
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge decode wrong");

    property p_reset_vals;
        disable iff (1'b0) sys_rst_in |=> st_ff.ovr == regulator_mode_control_pkg::RST_OVR
        && st_ff.core == regulator_mode_control_pkg::RST_CORE_B;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

    property p_pct;
        st_ff.onev == regulator_mode_control_pkg::SEL_1
        |=> one_volt_lp_drop_pct_out == regulator_mode_control_pkg::PCT_4;
    endproperty
    a_pct: assert property (p_pct) else $error("percent trim wrong");

    property p_reserved;
        (s_axi_arvalid_in && s_axi_arready_out && rd_hit[1])
        |=> s_axi_rvalid_out && s_axi_rdata_out[7:2] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

endmodule

`default_nettype wire

// ===== core/regulator_mode_control_pkg.sv
// Constants for the converter rail mode and set point register bank.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package regulator_mode_control_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses (address = index * 4)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CORE_B = 6'h38;
    localparam logic [5:0] IDX_OVR = 6'h3B;
    localparam logic [5:0] IDX_DIS = 6'h3C;
    localparam logic [5:0] IDX_ONEV = 6'h30;
    localparam logic [7:0] ADDR_CORE_B = {IDX_CORE_B, 2'h0};
    localparam logic [7:0] ADDR_OVR = {IDX_OVR, 2'h0};
    localparam logic [7:0] ADDR_DIS = {IDX_DIS, 2'h0};
    localparam logic [7:0] ADDR_ONEV = {IDX_ONEV, 2'h0};

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] low_power_setpoint_sel;
        logic [1:0] normal_setpoint_sel;
        logic [1:0] exit_standby_mode_load;
        logic [1:0] rail_b_mode_field;
    } core_ctrl_t;

    localparam logic [7:0] RST_CORE_B = 8'h2A;
    localparam logic [5:0] RST_OVR = 6'h3F;
    localparam logic [1:0] RST_DIS = 2'h0;
    localparam logic [1:0] RST_ONEV = 2'h0;
    localparam int OVR_RAIL_B_BIT = 3;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_1 = 2'h1;
    localparam logic [1:0] SEL_2 = 2'h2;
    localparam logic [1:0] SEL_3 = 2'h3;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h2;
    localparam logic [1:0] MODE_FPWM = 2'h3;

    // ------------------------------------------------------------
    // Set points in mV, discharge in ohms, trims in percent
    // ------------------------------------------------------------
    localparam logic [9:0] MV_0P95 = 10'h3B6;
    localparam logic [9:0] MV_0P90 = 10'h384;
    localparam logic [9:0] MV_0P85 = 10'h352;
    localparam logic [9:0] MV_0P80 = 10'h320;
    localparam logic [9:0] MV_0P75 = 10'h2EE;
    localparam logic [9:0] MV_0P70 = 10'h2BC;
    localparam logic [9:0] OHM_NONE = 10'h000;
    localparam logic [9:0] OHM_125 = 10'h07D;
    localparam logic [9:0] OHM_225 = 10'h0E1;
    localparam logic [9:0] OHM_550 = 10'h226;
    localparam logic [2:0] PCT_NONE = 3'h0;
    localparam logic [2:0] PCT_4 = 3'h4;
    localparam logic [2:0] PCT_3 = 3'h3;
    localparam logic [2:0] PCT_2 = 3'h2;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== verification/axi_host_model.sv
// Host side of the rail register bank: an AXI4-Lite master and the standby pin.
// Assumes one clock shared with the device and calls made from the bench only.
`timescale 1ns/1ps
`default_nettype none

module axi_host_model (
    input wire logic clk_in,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [7:0] awaddr_out,
    output logic wvalid_out,
    input wire logic wready_in,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    input wire logic bvalid_in,
    output logic bready_out,
    input wire logic [1:0] bresp_in,
    output logic arvalid_out,
    input wire logic arready_in,
    output logic [7:0] araddr_out,
    input wire logic rvalid_in,
    output logic rready_out,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in,
    output logic standby_request_n_out
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    // Released addresses and data show the inverse; the write strobe keeps its last value
    initial begin
        awvalid_out = 1'h0;
        wvalid_out = 1'h0;
        bready_out = 1'h0;
        arvalid_out = 1'h0;
        rready_out = 1'h0;
        awaddr_out = 8'hA5;
        wdata_out = 32'h5A5A5A5A;
        wstrb_out = 4'h0;
        araddr_out = 8'h5A;
        standby_request_n_out = 1'h1;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge clk_in);
        awaddr_out <= a;
        wdata_out <= d;
        wstrb_out <= s;
        awvalid_out <= 1'h1;
        wvalid_out <= 1'h1;
        bready_out <= 1'h1;
        do begin
            @(posedge clk_in);
            if (awvalid_out && awready_in) begin
                awvalid_out <= 1'h0;
                awaddr_out <= ~a;
            end
            if (wvalid_out && wready_in) begin
                wvalid_out <= 1'h0;
                wdata_out <= ~d;
            end
        end while (!(bvalid_in && bready_out));
        bready_out <= 1'h0;
        r = bresp_in;
    endtask

    // Read data taken at the edge that shows rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        araddr_out <= a;
        arvalid_out <= 1'h1;
        rready_out <= 1'h1;
        do begin
            @(posedge clk_in);
            if (arvalid_out && arready_in) begin
                arvalid_out <= 1'h0;
                araddr_out <= ~a;
            end
        end while (!(rvalid_in && rready_out));
        rready_out <= 1'h0;
        d = rdata_in;
        r = rresp_in;
    endtask

    // Low level asks the device for standby
    task automatic stby(input logic v);
        @(posedge clk_in);
        standby_request_n_out <= v;
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_regulator_mode_control_regs.sv
// Self-checking bench for the rail mode and set point register bank.
// Assumes the host model file is compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_regulator_mode_control_regs;
    localparam logic [7:0] A_CB = regulator_mode_control_pkg::ADDR_CORE_B;
    localparam logic [7:0] A_OV = regulator_mode_control_pkg::ADDR_OVR;
    localparam logic [7:0] A_DS = regulator_mode_control_pkg::ADDR_DIS;
    localparam logic [7:0] A_OV1 = regulator_mode_control_pkg::ADDR_ONEV;
    // Word with no register behind it
    localparam logic [7:0] A_BAD = 8'h04;
    localparam logic [9:0] NRM [4] = '{10'h3B6, 10'h384, 10'h352, 10'h320};
    localparam logic [9:0] LPV [4] = '{10'h3B6, 10'h2BC, 10'h2EE, 10'h320};
    localparam logic [9:0] OHM [4] = '{10'h000, 10'h07D, 10'h0E1, 10'h226};
    localparam logic [2:0] PCT [4] = '{3'h0, 3'h4, 3'h3, 3'h2};

    logic clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, sby_n, act, en, fp;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, dat;
    logic [3:0] ws;
    logic [1:0] bresp, rresp, rsp;
    logic [9:0] sp, ohms;
    logic [5:0] fa;
    logic [2:0] pct;
    int n_mismatch = 0;
    int compares = 0;

    // Clock at 25 ns period
    always #12.5 clk_in = ~clk_in;

    axi_host_model host (.clk_in(clk_in), .awvalid_out(awv), .awready_in(awr),
        .awaddr_out(awa), .wvalid_out(wv), .wready_in(wr_rdy), .wdata_out(wd),
        .wstrb_out(ws), .bvalid_in(bv), .bready_out(br), .bresp_in(bresp),
        .arvalid_out(arv), .arready_in(arr), .araddr_out(ara), .rvalid_in(rv),
        .rready_out(rr), .rdata_in(rdat), .rresp_in(rresp), .standby_request_n_out(sby_n));

    regulator_mode_control_regs dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .standby_request_n_in(sby_n), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
        .standby_active_out(act), .rail_b_setpoint_mv_out(sp), .rail_b_enable_out(en),
        .rail_b_forced_pwm_out(fp), .rail_force_auto_out(fa), .io_discharge_ohms_out(ohms),
        .one_volt_lp_drop_pct_out(pct));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, {24'h0, d}, 4'hF, rsp);
        chk(rsp, 2'h0);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, dat, rsp);
        chk(rsp, 2'h0);
        chk(dat, {24'h0, exp});
    endtask

    // Step off the edge so outputs have settled
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        test_done;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        wait_n(2);
        rreg(A_CB, 8'h2A);
        rreg(A_OV, 8'h3F);
        rreg(A_DS, 8'h00);
        rreg(A_OV1, 8'h00);
        chk(sp, NRM[2]);
        chk(en, 1'h1);
        chk(fa, 6'h00);
        // Unmapped place answers with a decode error and zero data
        host.wr(A_BAD, 32'hFF, 4'hF, rsp);
        chk(rsp, 2'h3);
        host.rd(A_BAD, dat, rsp);
        chk(rsp, 2'h3);
        chk(dat, 32'h0);
        // Read-only high bits must not disturb the writable ones
        wreg(A_OV, 8'hFF);
        rreg(A_OV, 8'h3F);
        wreg(A_DS, 8'hFE);
        rreg(A_DS, 8'h02);
        host.wr(A_DS, 32'h3, 4'hE, rsp);
        chk(rsp, 2'h0);
        rreg(A_DS, 8'h02);
        // Only the low strobe counts; upper data bits fall away
        host.wr(A_DS, 32'hFFFFFF01, 4'h1, rsp);
        chk(rsp, 2'h0);
        rreg(A_DS, 8'h01);
        // Low address bits are ignored, the word still answers
        host.rd(A_DS + 8'h03, dat, rsp);
        chk(rsp, 2'h0);
        chk(dat, 32'h1);
        // Every code of the normal select, mode, discharge and percentage fields
        for (int i = 0; i < 4; i++) begin
            wreg(A_CB, {2'h0, i[1:0], 2'h0, i[1:0]});
            wreg(A_DS, {6'h0, i[1:0]});
            wreg(A_OV1, {6'h0, i[1:0]});
            wait_n(2);
            chk(sp, NRM[i]);
            chk(en, i != 0);
            chk(fp, i == 3);
            chk(ohms, OHM[i]);
            chk(pct, PCT[i]);
        end
        // Standby set points, normal select held at code 00 (0.95 V)
        for (int i = 0; i < 4; i++) begin
            wreg(A_CB, {i[1:0], 6'h02});
            host.stby(1'h0);
            wait_n(5);
            chk(act, 1'h1);
            chk(sp, LPV[i]);
            host.stby(1'h1);
            wait_n(5);
            chk(act, 1'h0);
            chk(sp, NRM[0]);
        end
        // Exit edge reloads the mode bits, code 00 leaves them alone
        for (int i = 0; i < 4; i++) begin
            wreg(A_CB, {4'h0, i[1:0], 2'h3});
            host.stby(1'h0);
            wait_n(5);
            host.stby(1'h1);
            wait_n(6);
            rreg(A_CB, {4'h0, i[1:0], (i == 0) ? 2'h3 : i[1:0]});
        end
        // Override bits against every mode, rail b bit cleared then set
        for (int o = 0; o < 2; o++) begin
            for (int m = 0; m < 4; m++) begin
                wreg(A_OV, (o == 1) ? 8'h3F : 8'h15);
                wreg(A_CB, {6'h0, m[1:0]});
                host.stby(1'h0);
                wait_n(5);
                chk(en, m != 0);
                chk(fp, (m == 3) && (o == 1));
                chk(fa, (o == 1) ? 6'h00 : 6'h2A);
                host.stby(1'h1);
                wait_n(5);
            end
        end
        test_done;
    end
endmodule
`default_nettype wire
